/* File: mcx_pkg.sv */
// mcx_pkg: constants, types and register map of the instruction
// execute block; assumes a 32-bit AHB-Lite bus and one 10 MHz clock.
package mcx_pkg;

  // register byte offsets
  localparam logic [7:0] MCX_CMD_OFS    = 8'h00;
  localparam logic [7:0] MCX_ACC_OFS    = 8'h04;
  localparam logic [7:0] MCX_STATUS_OFS = 8'h08;
  localparam logic [7:0] MCX_PC_OFS     = 8'h0C;
  localparam logic [7:0] MCX_MEM_OFS    = 8'h40;

  // sizes
  localparam int MCX_MEM_WORDS  = 16;
  localparam int MCX_STACK_DEEP = 8;

  // reset values
  localparam logic [7:0]  MCX_ACC_RST = 8'h00;
  localparam logic [11:0] MCX_PC_RST  = 12'h000;
  localparam logic        MCX_EMI_RST = 1'b0;

  // fixed numbers of the datapath
  localparam logic [7:0]  MCX_ALL_ONES   = 8'hFF;
  localparam logic [7:0]  MCX_ONE        = 8'h01;
  localparam logic [11:0] MCX_PC_STEP    = 12'h001;
  localparam logic [11:0] MCX_IRQ_VECTOR = 12'h004;
  localparam logic [1:0]  MCX_CYC_ONE    = 2'h1;
  localparam logic [1:0]  MCX_CYC_TWO    = 2'h2;

  // status register field positions
  localparam int MCX_ST_EMI_BIT  = 8;
  localparam int MCX_ST_SKIP_BIT = 9;
  localparam int MCX_ST_ILL_BIT  = 10;
  localparam int MCX_ST_CYC_LSB  = 12;
  localparam int MCX_ST_SP_LSB   = 16;

  // instruction codes
  typedef enum logic [5:0] {
    MCX_OP_NOP      = 6'h00,
    MCX_OP_INC      = 6'h01,
    MCX_OP_INCA     = 6'h02,
    MCX_OP_JMP      = 6'h03,
    MCX_OP_MOV_AM   = 6'h04,
    MCX_OP_MOV_AX   = 6'h05,
    MCX_OP_MOV_MA   = 6'h06,
    MCX_OP_OR_AM    = 6'h07,
    MCX_OP_OR_AX    = 6'h08,
    MCX_OP_ORM      = 6'h09,
    MCX_OP_RET      = 6'h0A,
    MCX_OP_RET_AX   = 6'h0B,
    MCX_OP_IRET     = 6'h0C,
    MCX_OP_RL       = 6'h0D,
    MCX_OP_RLA      = 6'h0E,
    MCX_OP_RLTC     = 6'h0F,
    MCX_OP_RLTCA    = 6'h10,
    MCX_OP_RR       = 6'h11,
    MCX_OP_RRA      = 6'h12,
    MCX_OP_RRTC     = 6'h13,
    MCX_OP_RRTCA    = 6'h14,
    MCX_OP_SUBB_AM  = 6'h15,
    MCX_OP_SUBB_AX  = 6'h16,
    MCX_OP_SUBBM    = 6'h17,
    MCX_OP_DSKZ     = 6'h18,
    MCX_OP_DSKZA    = 6'h19,
    MCX_OP_SET      = 6'h1A,
    MCX_OP_SET_BIT  = 6'h1B,
    MCX_OP_CALL     = 6'h1C
  } mcx_op_type;

  // command word written to the command register
  typedef struct packed {
    logic [3:0]  rsvd_hi;
    logic [11:0] operand;   // immediate in [7:0], target in [11:0]
    logic [2:0]  rsvd_lo;
    logic [2:0]  bit_sel;
    logic [3:0]  mem_addr;
    logic [5:0]  op;
  } mcx_cmd_type;

  // arithmetic status flags
  typedef struct packed {
    logic carry_zero_flag;
    logic signed_carry_flag;
    logic result_out_of_range_flag;
    logic zero;
    logic aux_carry_flag;
    logic carry;
  } mcx_flags_type;

  localparam mcx_flags_type MCX_FLAGS_RST = 6'h00;

endpackage : mcx_pkg

/* File: mcx_core.sv */
// mcx_core: executes one instruction per command-register write not discarded by a skip,
// with accumulator, flags, program counter, stack and data memory.
// assumes a single AHB-Lite master and the 10 MHz clock hclk.
`timescale 1ns/100ps
`default_nettype none

module mcx_core
(
  input  wire logic        hclk,              // bus and core clock
  input  wire logic        hresetn,           // async reset, active low
  input  wire logic        hsel,              // slave select
  input  wire logic [31:0] haddr,             // byte address
  input  wire logic [1:0]  htrans,            // transfer type
  input  wire logic        hwrite,            // write when high
  input  wire logic [2:0]  hsize,             // transfer size
  input  wire logic [31:0] hwdata,            // write data
  input  wire logic        hready,            // bus ready in
  output logic             hreadyout,         // slave ready out
  output logic             hresp,             // always okay
  output logic      [31:0] hrdata,            // read data
  input  wire logic        irq_pending,       // an interrupt is waiting
  output logic             master_irq_enable, // global enable bit
  output logic             isr_entry          // pulse on service entry
);

  typedef enum logic {
    MCX_ST_RUN   = 1'b0,
    MCX_ST_DUMMY = 1'b1
  } mcx_state_type;

  mcx_state_type          state;
  logic                   dp_valid;
  logic                   dp_write;
  logic [7:0]             dp_addr;
  logic                   rd_done;
  logic [7:0]             acc;
  mcx_pkg::mcx_flags_type flags;
  logic [11:0]            pc;
  logic [2:0]             sp;
  logic [11:0]            stack [mcx_pkg::MCX_STACK_DEEP];
  logic [7:0]             dmem  [mcx_pkg::MCX_MEM_WORDS];
  logic                   skip_pending;
  logic                   illegal;
  logic [1:0]             last_cycles;

  mcx_pkg::mcx_cmd_type   cmd;
  logic                   busy;
  logic                   bus_wr;
  logic                   cmd_wr;
  logic                   exec_fire;
  logic                   dummy_fire;
  logic [7:0]             mval;
  logic [7:0]             imm;
  logic [11:0]            pc_inc;
  logic [11:0]            stack_top;

  // datapath results
  logic [7:0]             next_acc;
  logic                   acc_we;
  logic [7:0]             next_mem;
  logic                   mem_we;
  mcx_pkg::mcx_flags_type next_flags;
  logic [11:0]            next_pc;
  logic                   push;
  logic                   pop;
  logic                   two_cycle;
  logic                   take_skip;
  logic                   set_emi;
  logic                   enter_isr;
  logic                   next_illegal;

  // subtract helpers
  logic [8:0]             sub_full;
  logic [4:0]             sub_low;
  logic [7:0]             sub_opnd;
  logic                   borrow_in;

  assign cmd       = mcx_pkg::mcx_cmd_type'(hwdata);
  assign busy      = (state == MCX_ST_DUMMY);
  assign bus_wr    = dp_valid && dp_write && !busy;
  assign cmd_wr    = bus_wr && (dp_addr == mcx_pkg::MCX_CMD_OFS);
  assign exec_fire = cmd_wr && !skip_pending;
  assign dummy_fire = cmd_wr && skip_pending;
  assign mval      = dmem[cmd.mem_addr];
  assign imm       = cmd.operand[7:0];
  assign pc_inc    = pc + mcx_pkg::MCX_PC_STEP;
  assign stack_top = stack[sp - 3'd1];
  assign hresp     = 1'b0;

  // handshake: stall during the dummy cycle, reads take one wait
  always_comb
  begin
    if (!dp_valid)
      hreadyout = 1'b1;
    else if (busy)
      hreadyout = 1'b0;
    else if (dp_write)
      hreadyout = 1'b1;
    else
      hreadyout = rd_done;
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else if (hready)
    begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr  <= {haddr[7:2], 2'b00};
    end
  end

  // read data register, loaded in the first read data cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done <= 1'b0;
      hrdata  <= 32'h0000_0000;
    end
    else if (dp_valid && !dp_write && !busy && !rd_done)
    begin
      rd_done <= 1'b1;
      if (dp_addr >= mcx_pkg::MCX_MEM_OFS)
        hrdata <= {24'h00_0000, dmem[dp_addr[5:2]]};
      else
        unique case (dp_addr)
          mcx_pkg::MCX_ACC_OFS:    hrdata <= {24'h00_0000, acc};
          mcx_pkg::MCX_STATUS_OFS: hrdata <= {13'h0000, sp,
                                     2'b00, last_cycles, 1'b0, illegal,
                                     skip_pending, master_irq_enable,
                                     2'b00, flags};
          mcx_pkg::MCX_PC_OFS:     hrdata <= {20'h0_0000, pc};
          default:                 hrdata <= 32'h0000_0000;
        endcase
    end
    else
      rd_done <= 1'b0;
  end

  // subtract with borrow: acc minus operand minus inverted carry
  always_comb
  begin
    sub_opnd  = (cmd.op == mcx_pkg::MCX_OP_SUBB_AX) ? imm : mval;
    borrow_in = ~flags.carry;
    sub_full  = {1'b0, acc} - {1'b0, sub_opnd} - {8'h00, borrow_in};
    sub_low   = {1'b0, acc[3:0]} - {1'b0, sub_opnd[3:0]}
              - {4'h0, borrow_in};
  end

  // instruction decode and result selection
  always_comb
  begin
    next_acc     = acc;
    acc_we       = 1'b0;
    next_mem     = mval;
    mem_we       = 1'b0;
    next_flags   = flags;
    next_pc      = pc_inc;
    push         = 1'b0;
    pop          = 1'b0;
    two_cycle    = 1'b0;
    take_skip    = 1'b0;
    set_emi      = 1'b0;
    enter_isr    = 1'b0;
    next_illegal = 1'b0;
    unique case (cmd.op)
      mcx_pkg::MCX_OP_NOP: ;
      mcx_pkg::MCX_OP_INC, mcx_pkg::MCX_OP_INCA:
      begin
        next_mem        = mval + mcx_pkg::MCX_ONE;
        next_flags.zero = (next_mem == 8'h00);
        if (cmd.op == mcx_pkg::MCX_OP_INC)
          mem_we = 1'b1;
        else
        begin
          next_acc = next_mem;
          acc_we   = 1'b1;
        end
      end
      mcx_pkg::MCX_OP_JMP:
      begin
        next_pc   = cmd.operand;
        two_cycle = 1'b1;
      end
      mcx_pkg::MCX_OP_CALL:
      begin
        push      = 1'b1;
        next_pc   = cmd.operand;
        two_cycle = 1'b1;
      end
      mcx_pkg::MCX_OP_MOV_AM:
      begin
        next_acc = mval;
        acc_we   = 1'b1;
      end
      mcx_pkg::MCX_OP_MOV_AX:
      begin
        next_acc = imm;
        acc_we   = 1'b1;
      end
      mcx_pkg::MCX_OP_MOV_MA:
      begin
        next_mem = acc;
        mem_we   = 1'b1;
      end
      mcx_pkg::MCX_OP_OR_AM, mcx_pkg::MCX_OP_OR_AX,
      mcx_pkg::MCX_OP_ORM:
      begin
        next_mem = acc | ((cmd.op == mcx_pkg::MCX_OP_OR_AX) ? imm : mval);
        next_flags.zero = (next_mem == 8'h00);
        if (cmd.op == mcx_pkg::MCX_OP_ORM)
          mem_we = 1'b1;
        else
        begin
          next_acc = next_mem;
          acc_we   = 1'b1;
        end
      end
      mcx_pkg::MCX_OP_RET, mcx_pkg::MCX_OP_RET_AX:
      begin
        pop       = 1'b1;
        next_pc   = stack_top;
        two_cycle = 1'b1;
        if (cmd.op == mcx_pkg::MCX_OP_RET_AX)
        begin
          next_acc = imm;
          acc_we   = 1'b1;
        end
      end
      mcx_pkg::MCX_OP_IRET:
      begin
        two_cycle = 1'b1;
        if (irq_pending)
        begin
          enter_isr = 1'b1;
          next_pc   = mcx_pkg::MCX_IRQ_VECTOR;
        end
        else
        begin
          pop     = 1'b1;
          next_pc = stack_top;
          set_emi = 1'b1;
        end
      end
      mcx_pkg::MCX_OP_RL, mcx_pkg::MCX_OP_RLA:
      begin
        next_mem = {mval[6:0], mval[7]};
        mem_we   = (cmd.op == mcx_pkg::MCX_OP_RL);
        acc_we   = (cmd.op == mcx_pkg::MCX_OP_RLA);
        next_acc = acc_we ? next_mem : acc;
      end
      mcx_pkg::MCX_OP_RLTC, mcx_pkg::MCX_OP_RLTCA:
      begin
        next_mem         = {mval[6:0], flags.carry};
        next_flags.carry = mval[7];
        mem_we   = (cmd.op == mcx_pkg::MCX_OP_RLTC);
        acc_we   = (cmd.op == mcx_pkg::MCX_OP_RLTCA);
        next_acc = acc_we ? next_mem : acc;
      end
      mcx_pkg::MCX_OP_RR, mcx_pkg::MCX_OP_RRA:
      begin
        next_mem = {mval[0], mval[7:1]};
        mem_we   = (cmd.op == mcx_pkg::MCX_OP_RR);
        acc_we   = (cmd.op == mcx_pkg::MCX_OP_RRA);
        next_acc = acc_we ? next_mem : acc;
      end
      mcx_pkg::MCX_OP_RRTC, mcx_pkg::MCX_OP_RRTCA:
      begin
        next_mem         = {flags.carry, mval[7:1]};
        next_flags.carry = mval[0];
        mem_we   = (cmd.op == mcx_pkg::MCX_OP_RRTC);
        acc_we   = (cmd.op == mcx_pkg::MCX_OP_RRTCA);
        next_acc = acc_we ? next_mem : acc;
      end
      mcx_pkg::MCX_OP_SUBB_AM, mcx_pkg::MCX_OP_SUBB_AX,
      mcx_pkg::MCX_OP_SUBBM:
      begin
        next_mem = sub_full[7:0];
        next_flags.carry          = ~sub_full[8];
        next_flags.aux_carry_flag = ~sub_low[4];
        next_flags.zero           = (sub_full[7:0] == 8'h00);
        next_flags.result_out_of_range_flag =
          (acc[7] != sub_opnd[7]) && (sub_full[7] != acc[7]);
        next_flags.signed_carry_flag =
          next_flags.result_out_of_range_flag ^ sub_full[7];
        next_flags.carry_zero_flag = next_flags.zero && flags.zero;
        if (cmd.op == mcx_pkg::MCX_OP_SUBBM)
          mem_we = 1'b1;
        else
        begin
          next_acc = next_mem;
          acc_we   = 1'b1;
        end
      end
      mcx_pkg::MCX_OP_DSKZ, mcx_pkg::MCX_OP_DSKZA:
      begin
        next_mem  = mval - mcx_pkg::MCX_ONE;
        take_skip = (next_mem == 8'h00);
        mem_we    = (cmd.op == mcx_pkg::MCX_OP_DSKZ);
        acc_we    = (cmd.op == mcx_pkg::MCX_OP_DSKZA);
        next_acc  = acc_we ? next_mem : acc;
      end
      mcx_pkg::MCX_OP_SET:
      begin
        next_mem = mcx_pkg::MCX_ALL_ONES;
        mem_we   = 1'b1;
      end
      mcx_pkg::MCX_OP_SET_BIT:
      begin
        next_mem = mval | (mcx_pkg::MCX_ONE << cmd.bit_sel);
        mem_we   = 1'b1;
      end
      default:
        next_illegal = 1'b1;
    endcase
  end

  // dummy cycle after jumps, returns and the skipped instruction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= MCX_ST_RUN;
    else
      unique case (state)
        MCX_ST_RUN:
          if ((exec_fire && two_cycle) || dummy_fire)
            state <= MCX_ST_DUMMY;
        MCX_ST_DUMMY:
          state <= MCX_ST_RUN;
      endcase
  end

  // skip request carried to the following instruction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      skip_pending <= 1'b0;
    else if (exec_fire)
      skip_pending <= take_skip;
    else if (dummy_fire)
      skip_pending <= 1'b0;
  end

  // cost of the most recent instruction and decode error
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_cycles <= 2'h0;
      illegal     <= 1'b0;
    end
    else if (exec_fire)
    begin
      last_cycles <= two_cycle ? mcx_pkg::MCX_CYC_TWO
                               : mcx_pkg::MCX_CYC_ONE;
      illegal     <= next_illegal;
    end
    else if (dummy_fire)
      last_cycles <= mcx_pkg::MCX_CYC_TWO;
  end

  // accumulator
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc <= mcx_pkg::MCX_ACC_RST;
    else if (exec_fire && acc_we)
      acc <= next_acc;
    else if (bus_wr && dp_addr == mcx_pkg::MCX_ACC_OFS)
      acc <= hwdata[7:0];
  end

  // status flags and global interrupt enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags             <= mcx_pkg::MCX_FLAGS_RST;
      master_irq_enable <= mcx_pkg::MCX_EMI_RST;
    end
    else if (exec_fire)
    begin
      flags <= next_flags;
      if (set_emi)
        master_irq_enable <= 1'b1;
    end
    else if (bus_wr && dp_addr == mcx_pkg::MCX_STATUS_OFS)
    begin
      flags             <= mcx_pkg::mcx_flags_type'(hwdata[5:0]);
      master_irq_enable <= hwdata[mcx_pkg::MCX_ST_EMI_BIT];
    end
  end

  // program counter and service entry pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc        <= mcx_pkg::MCX_PC_RST;
      isr_entry <= 1'b0;
    end
    else
    begin
      isr_entry <= exec_fire && enter_isr;
      if (exec_fire)
        pc <= next_pc;
      else if (dummy_fire)
        pc <= pc_inc;
      else if (bus_wr && dp_addr == mcx_pkg::MCX_PC_OFS)
        pc <= hwdata[11:0];
    end
  end

  // return stack
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sp <= 3'h0;
    else if (exec_fire && push)
    begin
      stack[sp] <= pc_inc;
      sp        <= sp + 3'd1;
    end
    else if (exec_fire && pop)
      sp <= sp - 3'd1;
  end

  // data memory, one generate branch per byte
  for (genvar i = 0; i < mcx_pkg::MCX_MEM_WORDS; i++)
  begin : g_mem
    always_ff @(posedge hclk)
    begin
      if (exec_fire && mem_we && cmd.mem_addr == 4'(i))
        dmem[i] <= next_mem;
      else if (bus_wr && dp_addr[7:6] == 2'b01 && dp_addr[5:2] == 4'(i))
        dmem[i] <= hwdata[7:0];
    end
  end

endmodule : mcx_core

`default_nettype wire

/* File: mcx_core_monitor.sv */
// mcx_core_monitor: bus-side assertions for the execute block.
// assumes one master and hready tied to hreadyout.
`timescale 1ns/100ps
`default_nettype none

module mcx_core_monitor
(
  input wire logic        hclk,              // clock
  input wire logic        hresetn,           // reset, active low
  input wire logic        hsel,              // select
  input wire logic [31:0] haddr,             // address
  input wire logic [1:0]  htrans,            // transfer type
  input wire logic        hwrite,            // write
  input wire logic [2:0]  hsize,             // size
  input wire logic [31:0] hwdata,            // write data
  input wire logic        hready,            // ready in
  input wire logic        hreadyout,         // ready out
  input wire logic        hresp,             // response
  input wire logic [31:0] hrdata,            // read data
  input wire logic        irq_pending,       // interrupt waiting
  input wire logic        master_irq_enable, // global enable
  input wire logic        isr_entry          // service entry
);
  logic       dp_q;     // data phase open
  logic       dp_wr;    // data phase is a write
  logic [5:0] dp_idx;   // word index of the data phase
  logic       dp_wait;  // data phase has stalled
  logic       take;     // address phase taken now
  logic       done;     // write data phase ends now
  logic       iret_cmd; // interrupt return executes now
  logic       st_wr;    // status write lands now
  logic       plain_op; // single-cycle command code on hwdata

  // decode of the current bus state
  assign take     = hsel && htrans[1] && hready;
  assign done     = dp_q && dp_wr && hreadyout;
  assign iret_cmd = done && dp_idx == 6'h00 &&
                    hwdata[5:0] == mcx_pkg::MCX_OP_IRET;
  assign st_wr    = done && dp_idx == 6'h02;
  assign plain_op = hwdata[5:0] inside {mcx_pkg::MCX_OP_NOP,
                    mcx_pkg::MCX_OP_INC, mcx_pkg::MCX_OP_MOV_AX,
                    mcx_pkg::MCX_OP_OR_AX, mcx_pkg::MCX_OP_SET};

  // track the open data phase and whether it stalled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_q    <= 1'b0;
      dp_wr   <= 1'b0;
      dp_idx  <= 6'h00;
      dp_wait <= 1'b0;
    end
    else if (hready)
    begin
      dp_q    <= take;
      dp_wr   <= hwrite;
      dp_idx  <= haddr[7:2];
      dp_wait <= 1'b0;
    end
    else
      dp_wait <= 1'b1;
  end

  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // a command write that completes with no stall
  sequence s_exec(logic [5:0] code);
    done && !dp_wait && dp_idx == 6'h00 && hwdata[5:0] == code;
  endsequence

  a_hresp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout)
    else $error("read answered without a wait");
  a_jmp_stall: assert property
    (s_exec(mcx_pkg::MCX_OP_JMP) ##0 take |=> !hreadyout)
    else $error("jump did not insert a dummy cycle");
  a_plain_nowait: assert property
    (done && !dp_wait && dp_idx == 6'h00 && plain_op && take && hwrite
     |=> hreadyout)
    else $error("single-cycle command stalled the next write");
  a_iret_enable: assert property
    (s_exec(mcx_pkg::MCX_OP_IRET) ##0 !irq_pending |=> master_irq_enable)
    else $error("interrupt return left enable low");
  a_iret_vector: assert property
    (s_exec(mcx_pkg::MCX_OP_IRET) ##0 irq_pending
     |=> $stable(master_irq_enable) ##[0:1] isr_entry)
    else $error("pending interrupt not entered");
  a_enable_hold: assert property
    ($changed(master_irq_enable) |-> $past(iret_cmd || st_wr))
    else $error("enable changed without cause");
  a_isr_pulse: assert property (isr_entry |=> !isr_entry)
    else $error("service entry longer than one cycle");
  a_isr_cause: assert property
    ($rose(isr_entry) |-> $past(iret_cmd, 1) || $past(iret_cmd, 2))
    else $error("service entry without interrupt return");
endmodule : mcx_core_monitor

bind mcx_core mcx_core_monitor u_mcx_core_monitor
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .irq_pending(irq_pending),
  .master_irq_enable(master_irq_enable), .isr_entry(isr_entry)
);

`default_nettype wire

/* File: mcx_core_tb.sv */
// mcx_core_tb: self-checking bench for the execute block.
// assumes one AHB-Lite slave, hready = hreadyout.
`timescale 1ns/100ps
`default_nettype none

module mcx_core_tb;
  `define CHK(nm, exp, got) \
    begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
        error_cnt++; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
      end \
    end

  typedef struct packed {
    logic [5:0] op;
    logic [3:0] m;
    logic [2:0] b;
    logic [7:0] x, a0, m0;
    logic [5:0] f0;
    logic [7:0] ea, em;
    logic [5:0] ef;
  } mcx_row_type;

  localparam logic [7:0] CMD_A = mcx_pkg::MCX_CMD_OFS;
  localparam logic [7:0] ACC_A = mcx_pkg::MCX_ACC_OFS;
  localparam logic [7:0] ST_A  = mcx_pkg::MCX_STATUS_OFS;
  localparam logic [7:0] PC_A  = mcx_pkg::MCX_PC_OFS;
  localparam logic [7:0] MEM_A = mcx_pkg::MCX_MEM_OFS;

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        irq_pending, master_irq_enable, isr_entry;
  logic [11:0] pc0;
  int          wv, isr_cnt, error_cnt, comparisons;
  mcx_row_type rows [24];

  assign hready = hreadyout;

  mcx_core u_mcx_core
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq_pending(irq_pending),
    .master_irq_enable(master_irq_enable), .isr_entry(isr_entry)
  );

  // clock of 100 ns
  always #50 hclk = ~hclk;

  // count service-entry pulses
  always @(posedge hclk)
  begin
    if (isr_entry === 1'b1)
      isr_cnt <= isr_cnt + 1;
  end

  function automatic logic [31:0] cw(input logic [5:0] op,
    input logic [3:0] m, input logic [2:0] b, input logic [11:0] x);
    return {4'h0, x, 3'h0, b, m, op};
  endfunction : cw

  // wait for hready, counting waits
  task automatic wait_rdy();
    wv = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      wv++;
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    haddr  <= 32'(a);
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask : xfer

  // write followed at once by a second transfer
  task automatic pair(input logic [7:0] a1, input logic [31:0] d1,
    input logic wr2, input logic [7:0] a2, input logic [31:0] d2);
    haddr  <= 32'(a1);
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    haddr  <= 32'(a2);
    hwrite <= wr2;
    hwdata <= d1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d2;
    wait_rdy();
    rv = hrdata;
  endtask : pair

  task automatic cmd(input logic [5:0] op, input logic [3:0] m = 4'h0,
                     input logic [2:0] b = 3'h0, input logic [11:0] x = 12'h0);
    xfer(1'b1, CMD_A, cw(op, m, b, x));
  endtask : cmd

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // watchdog
  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    rows = '{
      '{6'h01,4'h1,3'h0,8'h00,8'h00,8'hff,6'h00,8'h00,8'h00,6'h04},
      '{6'h02,4'h2,3'h0,8'h00,8'h55,8'h7f,6'h3b,8'h80,8'h7f,6'h3b},
      '{6'h04,4'h3,3'h0,8'h00,8'h00,8'ha5,6'h3f,8'ha5,8'ha5,6'h3f},
      '{6'h05,4'h3,3'h0,8'h00,8'h12,8'h66,6'h00,8'h00,8'h66,6'h00},
      '{6'h06,4'h4,3'h0,8'h00,8'h5a,8'h00,6'h04,8'h5a,8'h5a,6'h04},
      '{6'h07,4'h6,3'h0,8'h00,8'h00,8'h00,6'h01,8'h00,8'h00,6'h05},
      '{6'h08,4'h6,3'h0,8'h0f,8'hf0,8'h00,6'h3f,8'hff,8'h00,6'h3b},
      '{6'h09,4'h7,3'h0,8'h00,8'h18,8'h81,6'h00,8'h18,8'h99,6'h00},
      '{6'h0d,4'h8,3'h0,8'h00,8'h00,8'h81,6'h00,8'h00,8'h03,6'h00},
      '{6'h0e,4'h9,3'h0,8'h00,8'h00,8'h40,6'h01,8'h80,8'h40,6'h01},
      '{6'h0f,4'ha,3'h0,8'h00,8'h00,8'h80,6'h00,8'h00,8'h00,6'h01},
      '{6'h10,4'hb,3'h0,8'h00,8'h00,8'h01,6'h01,8'h03,8'h01,6'h00},
      '{6'h11,4'hc,3'h0,8'h00,8'h00,8'h01,6'h04,8'h00,8'h80,6'h04},
      '{6'h12,4'hd,3'h0,8'h00,8'h00,8'h02,6'h00,8'h01,8'h02,6'h00},
      '{6'h13,4'he,3'h0,8'h00,8'h00,8'h01,6'h00,8'h00,8'h00,6'h01},
      '{6'h14,4'hf,3'h0,8'h00,8'h00,8'h02,6'h01,8'h81,8'h02,6'h00},
      '{6'h15,4'h0,3'h0,8'h00,8'h03,8'h01,6'h01,8'h02,8'h01,6'h03},
      '{6'h16,4'h0,3'h0,8'h01,8'h00,8'h01,6'h01,8'hff,8'h01,6'h10},
      '{6'h17,4'h1,3'h0,8'h00,8'h01,8'h01,6'h05,8'h01,8'h00,6'h27},
      '{6'h16,4'h1,3'h0,8'h00,8'h80,8'h00,6'h00,8'h7f,8'h00,6'h19},
      '{6'h1a,4'h2,3'h0,8'h00,8'h00,8'h00,6'h00,8'h00,8'hff,6'h00},
      '{6'h1b,4'h3,3'h5,8'h00,8'h00,8'h01,6'h00,8'h00,8'h21,6'h00},
      '{6'h18,4'h4,3'h0,8'h00,8'h00,8'h02,6'h3f,8'h00,8'h01,6'h3f},
      '{6'h19,4'h5,3'h0,8'h00,8'h00,8'h05,6'h00,8'h04,8'h05,6'h00}};
    {hclk, hresetn, hwrite, irq_pending} = 4'h0;
    {haddr, hwdata} = 64'h0000_0000_0000_0000;
    {hsel, hsize, htrans} = 6'h28;
    {isr_cnt, error_cnt, comparisons} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values and an unmapped address
    `CHK("enable rst", 1'b0, master_irq_enable)
    rd(ST_A);
    `CHK("status rst", 14'h0000, {rv[18:16], rv[10:0]})
    rd(PC_A);
    `CHK("pc rst", 12'h000, rv[11:0])
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20);
    `CHK("unmapped", 32'h0000_0000, rv)
    // table rows
    for (int i = 0; i < 24; i++)
    begin
      xfer(1'b1, MEM_A + {2'h0, rows[i].m, 2'h0}, 32'(rows[i].m0));
      xfer(1'b1, ACC_A, 32'(rows[i].a0));
      xfer(1'b1, ST_A, 32'(rows[i].f0));
      cmd(rows[i].op, rows[i].m, rows[i].b, 12'(rows[i].x));
      rd(ACC_A);
      `CHK("acc", rows[i].ea, rv[7:0])
      rd(MEM_A + {2'h0, rows[i].m, 2'h0});
      `CHK("mem", rows[i].em, rv[7:0])
      rd(ST_A);
      `CHK("flags", rows[i].ef, rv[5:0])
    end
    // back-to-back pairs
    pair(CMD_A, cw(mcx_pkg::MCX_OP_JMP, 4'h0, 3'h0, 12'h123), 1'b0,
         PC_A, 32'h0);
    `CHK("pc jmp", 12'h123, rv[11:0])
    `CHK("jmp waits", 2, wv)
    pair(CMD_A, cw(mcx_pkg::MCX_OP_NOP, 4'h0, 3'h0, 12'h000), 1'b1,
         ACC_A, 32'h0000_005a);
    `CHK("nop waits", 0, wv)
    rd(PC_A);
    `CHK("pc nop", 12'h124, rv[11:0])
    // call and both returns
    xfer(1'b1, ST_A, 32'h0000_002a);
    xfer(1'b1, PC_A, 32'h0000_0010);
    cmd(mcx_pkg::MCX_OP_CALL, 4'h0, 3'h0, 12'h200);
    cmd(mcx_pkg::MCX_OP_RET_AX, 4'h0, 3'h0, 12'h077);
    rd(PC_A);
    `CHK("pc ret", 12'h011, rv[11:0])
    rd(ACC_A);
    `CHK("acc ret", 8'h77, rv[7:0])
    cmd(mcx_pkg::MCX_OP_CALL, 4'h0, 3'h0, 12'h300);
    cmd(mcx_pkg::MCX_OP_RET);
    rd(PC_A);
    `CHK("pc ret2", 12'h012, rv[11:0])
    // interrupt return, idle then pending
    for (int k = 0; k < 2; k++)
    begin
      cmd(mcx_pkg::MCX_OP_CALL, 4'h0, 3'h0, 12'h100);
      xfer(1'b1, ST_A, 32'h0000_002a);
      irq_pending <= 1'(k);
      cmd(mcx_pkg::MCX_OP_IRET);
      irq_pending <= 1'b0;
      rd(ST_A);
      `CHK("flags iret", 6'h2a, rv[5:0])
      `CHK("enable iret", 1'(1 - k), master_irq_enable)
      `CHK("isr count", k, isr_cnt)
    end
    cmd(mcx_pkg::MCX_OP_IRET);
    rd(PC_A);
    `CHK("pc after isr", 12'h014, rv[11:0])
    // taken skips in both forms
    xfer(1'b1, MEM_A, 32'h0000_0001);
    xfer(1'b1, ACC_A, 32'h0000_0011);
    rd(PC_A);
    pc0 = rv[11:0];
    cmd(mcx_pkg::MCX_OP_DSKZ);
    rd(ST_A);
    `CHK("skip set", 3'h3, {rv[13:12], rv[9]})
    cmd(mcx_pkg::MCX_OP_MOV_AX, 4'h0, 3'h0, 12'h099);
    rd(PC_A);
    `CHK("pc skip", pc0 + 12'h002, rv[11:0])
    rd(ACC_A);
    `CHK("acc skip", 8'h11, rv[7:0])
    xfer(1'b1, MEM_A + 8'h04, 32'h0000_0001);
    cmd(mcx_pkg::MCX_OP_DSKZA, 4'h1, 3'h0, 12'h000);
    rd(ST_A);
    `CHK("skip acc", 1'b1, rv[9])
    cmd(mcx_pkg::MCX_OP_NOP);
    rd(MEM_A + 8'h04);
    `CHK("mem kept", 8'h01, rv[7:0])
    wrap_up();
  end
endmodule : mcx_core_tb

`default_nettype wire
